// *** src/bcpg_regs.vh ***
// ==========================================
// bcpg register map and timing constants
`ifndef BCPG_REGS_VH
`define BCPG_REGS_VH

// ==========================================
// clock, carrier, lock and recovery timing
`define BCPG_CLK_HZ        25000000
`define BCPG_PWM_HZ        22000
`define BCPG_PWM_PERIOD    (`BCPG_CLK_HZ / `BCPG_PWM_HZ)
`define BCPG_PERIOD_W      11
`define BCPG_INIT_PERIODS  2
`define BCPG_LOCK_TIME_MS  1000
`define BCPG_LOCK_CYCLES   (`BCPG_CLK_HZ / 1000 * `BCPG_LOCK_TIME_MS)
`define BCPG_RECOV_TIME_MS 4000
`define BCPG_RECOV_CYCLES  (`BCPG_CLK_HZ / 1000 * `BCPG_RECOV_TIME_MS)
`define BCPG_LOCK_CNT_W    28

// ==========================================
// register byte offsets
`define BCPG_OFS_CTRL      8'h00
`define BCPG_OFS_TORQUE    8'h04
`define BCPG_OFS_STATUS    8'h08
`define BCPG_OFS_IRQ_STAT  8'h0C
`define BCPG_OFS_IRQ_CLR   8'h10
`define BCPG_OFS_IRQ_EN    8'h14

// ==========================================
// fields and reset values
`define BCPG_CTRL_DIR      0
`define BCPG_CTRL_RST      1'h0
`define BCPG_TORQUE_RST    8'h00
`define BCPG_TORQUE_FULL   8'hFF
`define BCPG_IRQ_W         3
`define BCPG_IRQ_HALL      0
`define BCPG_IRQ_LOCK      1
`define BCPG_IRQ_BADCODE   2
`define BCPG_IRQ_RST       3'h0
`define BCPG_ST_HALL_LSB   0
`define BCPG_ST_LOCKED     3
`define BCPG_ST_RUN        4
`define BCPG_ST_INIT_DONE  5
`define BCPG_ST_GATE_ON    6
`define BCPG_ST_LOWPIN_LSB 7
`define BCPG_ZERO32        32'h0000_0000

`endif

// *** src/bcpg_carrier.v ***
`timescale 1ns/1ps
`default_nettype none
`include "bcpg_regs.vh"

// ==========================================
// pwm carrier and initial reset pulse
module bcpg_carrier #(
	parameter PERIOD      = `BCPG_PWM_PERIOD,
	parameter INIT_PERIOD = `BCPG_INIT_PERIODS
) (
	// clock and reset
	input  wire       clk,
	input  wire       arst_n,
	// duty request
	input  wire [7:0] duty,
	// carrier outputs
	output reg        carrier_on,
	output reg        init_done
);
	// full-width first, then cut on purpose to the counter width
	localparam [31:0] PER_32  = PERIOD;
	localparam [31:0] LAST_32 = PERIOD - 1;
	localparam [31:0] INIT_32 = INIT_PERIOD - 1;
	localparam [`BCPG_PERIOD_W-1:0] LAST = LAST_32[`BCPG_PERIOD_W-1:0];
	localparam [`BCPG_PERIOD_W-1:0] PER  = PER_32[`BCPG_PERIOD_W-1:0];
	localparam [1:0] INIT_LAST = INIT_32[1:0];

	reg  [`BCPG_PERIOD_W-1:0]   cnt;        // position in the period
	reg  [1:0]                  init_cnt;   // periods seen since reset
	wire [`BCPG_PERIOD_W+7:0]   prod;       // duty scaled to period
	wire [`BCPG_PERIOD_W-1:0]   thr;        // on-time in cycles

	// duty scales linearly, full code means no off time at all
	assign prod = duty * PER;
	assign thr  = (duty == `BCPG_TORQUE_FULL) ? PER :
		prod[`BCPG_PERIOD_W+7:8];

	// ==========================================
	// sawtooth counter and compare
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt        <= {`BCPG_PERIOD_W{1'b0}};
			carrier_on <= 1'b0;
		end else begin
			cnt        <= (cnt == LAST) ? {`BCPG_PERIOD_W{1'b0}} : cnt + 1'b1;
			carrier_on <= (cnt < thr);
		end
	end

	// ==========================================
	// initial reset: drive held off for whole periods
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			init_cnt  <= 2'h0;
			init_done <= 1'b0;
		end else if (!init_done && cnt == LAST) begin
			// same oscillator times the power-up hold
			init_cnt  <= init_cnt + 1'b1;
			init_done <= (init_cnt == INIT_LAST);
		end
	end
endmodule // bcpg_carrier

`default_nettype wire

// *** src/bcpg_lock.v ***
`timescale 1ns/1ps
`default_nettype none
`include "bcpg_regs.vh"

// ==========================================
// lock protection with automatic recovery
module bcpg_lock #(
	parameter LOCK_CYCLES  = `BCPG_LOCK_CYCLES,
	parameter RECOV_CYCLES = `BCPG_RECOV_CYCLES
) (
	// clock and reset
	input  wire clk,
	input  wire arst_n,
	// supervision inputs
	input  wire armed,      // drive wanted and protection fitted
	input  wire hall_step,  // one-cycle pulse per valid hall change
	// state
	output reg  locked
);
	// full-width first, then cut on purpose to the counter width
	localparam [31:0] LOCK_32  = LOCK_CYCLES - 1;
	localparam [31:0] RECOV_32 = RECOV_CYCLES - 1;
	localparam [`BCPG_LOCK_CNT_W-1:0] LOCK_LAST  =
		LOCK_32[`BCPG_LOCK_CNT_W-1:0];
	localparam [`BCPG_LOCK_CNT_W-1:0] RECOV_LAST =
		RECOV_32[`BCPG_LOCK_CNT_W-1:0];

	reg [`BCPG_LOCK_CNT_W-1:0] cnt; // stall or recovery time

	// ==========================================
	// stall watchdog, then off-time, then retry
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt    <= {`BCPG_LOCK_CNT_W{1'b0}};
			locked <= 1'b0;
		end else if (locked) begin
			// recovery runs even if drive is withdrawn
			if (cnt == RECOV_LAST) begin
				cnt    <= {`BCPG_LOCK_CNT_W{1'b0}};
				locked <= 1'b0;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end else if (!armed || hall_step) begin
			// rotation or idle restarts the stall window
			cnt <= {`BCPG_LOCK_CNT_W{1'b0}};
		end else if (cnt == LOCK_LAST) begin
			cnt    <= {`BCPG_LOCK_CNT_W{1'b0}};
			locked <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end
endmodule // bcpg_lock

`default_nettype wire

// *** src/bcpg_core.v ***
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bcpg_regs.vh"

module bcpg_core #(
	parameter HALL_W       = 1,
	parameter LOCK_CYCLES  = `BCPG_LOCK_CYCLES,
	parameter RECOV_CYCLES = `BCPG_RECOV_CYCLES
) (
	// clock and reset
	input  wire              CORE_CLK,
	input  wire              ARST_N,
	// wishbone slave
	input  wire              WB_CYC_I,
	input  wire              WB_STB_I,
	input  wire              WB_WE_I,
	input  wire [7:0]        WB_ADR_I,
	input  wire [3:0]        WB_SEL_I,
	input  wire [31:0]       WB_DAT_I,
	output reg  [31:0]       WB_DAT_O,
	output reg               WB_ACK_O,
	// control pins
	input  wire              START_STOP_INPUT,
	input  wire              PULSE_DUTY_INPUT,
	input  wire              LOCK_TIMER_INPUT,
	// hall comparator inputs
	input  wire [HALL_W-1:0] HALL_A_POS,
	input  wire [HALL_W-1:0] HALL_A_NEG,
	input  wire [HALL_W-1:0] HALL_B_POS,
	input  wire [HALL_W-1:0] HALL_B_NEG,
	input  wire [HALL_W-1:0] HALL_C_POS,
	input  wire [HALL_W-1:0] HALL_C_NEG,
	// high-side push-pull drives
	output wire              PHASE_A_HIGH_DRIVE,
	output wire              PHASE_B_HIGH_DRIVE,
	output wire              PHASE_C_HIGH_DRIVE,
	// low-side open-collector drives
	input  wire              PHASE_A_LOW_DRIVE_I,
	output wire              PHASE_A_LOW_DRIVE_O,
	output wire              PHASE_A_LOW_DRIVE_OE_N,
	input  wire              PHASE_B_LOW_DRIVE_I,
	output wire              PHASE_B_LOW_DRIVE_O,
	output wire              PHASE_B_LOW_DRIVE_OE_N,
	input  wire              PHASE_C_LOW_DRIVE_I,
	output wire              PHASE_C_LOW_DRIVE_OE_N,
	output wire              PHASE_C_LOW_DRIVE_O,
	// status and interrupt
	output reg               ROTATION_STATUS,
	output reg               IRQ
);
	// ==========================================
	// declarations
	wire [3*HALL_W-1:0]      pos_all;     // hall plus inputs, a in low
	wire [3*HALL_W-1:0]      neg_all;     // hall minus inputs
	wire [2:0]               hall_lvl;    // comparator result, a in low
	wire [2:0]               low_pin;     // low-side pin readback
	reg  [2:0]               hall_code;   // {a,b,c} sampled
	reg  [2:0]               hall_prev;   // last sample for edges
	reg                      stop_q;      // sampled start/stop
	reg                      gate_off_q;  // sampled pulse-duty
	reg                      lock_fit_q;  // sampled lock timer pin
	reg                      dir;         // direction select
	reg  [7:0]               torque;      // torque command
	reg  [`BCPG_IRQ_W-1:0]   irq_stat;    // sticky events
	reg  [`BCPG_IRQ_W-1:0]   irq_en;      // event enables
	reg  [2:0]               high_q;      // high drive flops, a in low
	reg  [2:0]               low_oe_n;    // low drive enables, a in low
	reg  [2:0]               src;         // sourcing phase, one-hot
	reg  [2:0]               sink;        // sinking phase, one-hot
	reg                      bad_code;    // hall code not usable
	reg  [2:0]               next_high;   // next high drive
	reg  [2:0]               next_low;    // next low drive
	reg  [31:0]              rd_mux;      // read data before flop
	reg                      locked_prev; // for lock entry edge
	wire [2:0]               eff_code;    // code after direction
	wire                     carrier_on;  // modulator on-time
	wire                     init_done;   // power-up hold over
	wire                     locked;      // lock protection active
	wire                     run_mode;    // start mode selected
	wire                     drive_ok;    // all gates open
	wire                     hall_step;   // valid hall change
	wire                     wr_en;       // write commits this edge
	wire [`BCPG_IRQ_W-1:0]   ev;          // event pulses
	wire [`BCPG_IRQ_W-1:0]   clr;         // clear strobes

	// ==========================================
	// hall comparators, one per channel
	assign pos_all = {HALL_C_POS, HALL_B_POS, HALL_A_POS};
	assign neg_all = {HALL_C_NEG, HALL_B_NEG, HALL_A_NEG};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_hall
			// strict compare: equal levels read as low
			assign hall_lvl[gi] =
				pos_all[gi*HALL_W +: HALL_W] >
				neg_all[gi*HALL_W +: HALL_W];
		end
	endgenerate

	// ==========================================
	// pin sampling
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			// reset as stopped and gated off
			hall_code  <= 3'h0;
			hall_prev  <= 3'h0;
			stop_q     <= 1'b1;
			gate_off_q <= 1'b1;
			lock_fit_q <= 1'b0;
		end else begin
			hall_code  <= {hall_lvl[0], hall_lvl[1], hall_lvl[2]};
			hall_prev  <= hall_code;
			// no pull-up here, board must set the level
			stop_q     <= START_STOP_INPUT;
			// an open pin reads high on the board, so off
			gate_off_q <= PULSE_DUTY_INPUT;
			// grounded pin means protection not fitted
			lock_fit_q <= LOCK_TIMER_INPUT;
		end
	end

	// ==========================================
	// mode and gating
	assign run_mode = ~stop_q;
	// analog speed loop relies on pulse-duty held low
	assign drive_ok = run_mode & ~gate_off_q & ~locked & init_done;
	assign hall_step = (hall_code != hall_prev) & ~bad_code;

	// ==========================================
	// commutation decode
	assign eff_code = hall_code ^ {3{dir}};

	// phase vectors are {c,b,a}; code order is {a,b,c}
	always @* begin
		src      = 3'h0;
		sink     = 3'h0;
		bad_code = 1'b0;
		case (eff_code)
			3'h5: begin
				src  = 3'h2;
				sink = 3'h1;
			end
			3'h4: begin
				src  = 3'h4;
				sink = 3'h1;
			end
			3'h6: begin
				src  = 3'h4;
				sink = 3'h2;
			end
			3'h2: begin
				src  = 3'h1;
				sink = 3'h2;
			end
			3'h3: begin
				src  = 3'h1;
				sink = 3'h4;
			end
			3'h1: begin
				src  = 3'h2;
				sink = 3'h4;
			end
			default: begin
				// all-high and all-low codes leave every output off
				bad_code = 1'b1;
			end
		endcase
	end

	// ==========================================
	// drive gating
	always @* begin
		// pwm chops only the source side; sink stays on all step
		// with full torque code the host gets 100% duty
		next_high = src & {3{drive_ok & carrier_on}};
		next_low  = sink & {3{drive_ok}};
		// belt and braces against shoot-through on a phase
		next_high = next_high & ~next_low;
	end

	// ==========================================
	// output flops, high side drives both levels
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			high_q   <= 3'h0;
			low_oe_n <= 3'h7;
		end else begin
			high_q   <= next_high;
			low_oe_n <= ~next_low;
		end
	end

	assign PHASE_A_HIGH_DRIVE     = high_q[0];
	assign PHASE_B_HIGH_DRIVE     = high_q[1];
	assign PHASE_C_HIGH_DRIVE     = high_q[2];
	// open collector: only ever pulls low, released otherwise
	assign PHASE_A_LOW_DRIVE_O    = 1'b0;
	assign PHASE_B_LOW_DRIVE_O    = 1'b0;
	assign PHASE_C_LOW_DRIVE_O    = 1'b0;
	assign PHASE_A_LOW_DRIVE_OE_N = low_oe_n[0];
	assign PHASE_B_LOW_DRIVE_OE_N = low_oe_n[1];
	assign PHASE_C_LOW_DRIVE_OE_N = low_oe_n[2];
	assign low_pin = {PHASE_C_LOW_DRIVE_I, PHASE_B_LOW_DRIVE_I,
		PHASE_A_LOW_DRIVE_I};

	// ==========================================
	// carrier and power-up hold
	bcpg_carrier u_carrier (
		.clk        (CORE_CLK),
		.arst_n     (ARST_N),
		.duty       (torque),
		.carrier_on (carrier_on),
		.init_done  (init_done)
	);

	// ==========================================
	// lock protection
	bcpg_lock #(
		.LOCK_CYCLES  (LOCK_CYCLES),
		.RECOV_CYCLES (RECOV_CYCLES)
	) u_lock (
		.clk       (CORE_CLK),
		.arst_n    (ARST_N),
		.armed     (lock_fit_q & run_mode & ~gate_off_q & init_done),
		.hall_step (hall_step),
		.locked    (locked)
	);

	// ==========================================
	// rotation status
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ROTATION_STATUS <= 1'b1;
			locked_prev     <= 1'b0;
		end else begin
			ROTATION_STATUS <= ~locked;
			locked_prev     <= locked;
		end
	end

	// ==========================================
	// wishbone slave, one wait state
	assign wr_en = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O & WB_SEL_I[0];

	// read mux; unmapped and write-only words read zero
	always @* begin
		rd_mux = `BCPG_ZERO32;
		case (WB_ADR_I)
			`BCPG_OFS_CTRL:     rd_mux[`BCPG_CTRL_DIR] = dir;
			`BCPG_OFS_TORQUE:   rd_mux[7:0] = torque;
			`BCPG_OFS_STATUS: begin
				rd_mux[`BCPG_ST_HALL_LSB +: 3]   = hall_code;
				rd_mux[`BCPG_ST_LOCKED]          = locked;
				rd_mux[`BCPG_ST_RUN]             = run_mode;
				rd_mux[`BCPG_ST_INIT_DONE]       = init_done;
				rd_mux[`BCPG_ST_GATE_ON]         = ~gate_off_q;
				rd_mux[`BCPG_ST_LOWPIN_LSB +: 3] = low_pin;
			end
			`BCPG_OFS_IRQ_STAT: rd_mux[`BCPG_IRQ_W-1:0] = irq_stat;
			`BCPG_OFS_IRQ_EN:   rd_mux[`BCPG_IRQ_W-1:0] = irq_en;
			default:            rd_mux = `BCPG_ZERO32;
		endcase
	end

	// ack one cycle after the strobe, dropped the cycle after
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= `BCPG_ZERO32;
		end else begin
			WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
			if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
				WB_DAT_O <= rd_mux;
			end
		end
	end

	// ==========================================
	// writable registers, commit on the acked edge
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			dir    <= `BCPG_CTRL_RST;
			torque <= `BCPG_TORQUE_RST;
			irq_en <= `BCPG_IRQ_RST;
		end else if (wr_en) begin
			case (WB_ADR_I)
				`BCPG_OFS_CTRL:   dir    <= WB_DAT_I[`BCPG_CTRL_DIR];
				`BCPG_OFS_TORQUE: torque <= WB_DAT_I[7:0];
				`BCPG_OFS_IRQ_EN: irq_en <= WB_DAT_I[`BCPG_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================
	// interrupt events
	assign ev[`BCPG_IRQ_HALL]    = hall_step;
	assign ev[`BCPG_IRQ_LOCK]    = locked & ~locked_prev;
	assign ev[`BCPG_IRQ_BADCODE] = bad_code & (hall_code != hall_prev);
	assign clr = (wr_en && WB_ADR_I == `BCPG_OFS_IRQ_CLR) ?
		WB_DAT_I[`BCPG_IRQ_W-1:0] : `BCPG_IRQ_RST;

	// set beats clear so a same-cycle event survives
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			irq_stat <= `BCPG_IRQ_RST;
			IRQ      <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~clr) | ev;
			// level output, one cycle behind the sticky bits
			IRQ      <= |(irq_stat & irq_en);
		end
	end
endmodule // bcpg_core

`default_nettype wire

// *** dv/bcpg_motor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// hall sensors and output transistors
module bcpg_motor #(
	parameter HALL_W = 1
) (
	// wanted hall state, bit2 is channel a
	input  wire logic [2:0]        hall_code,
	// comparator pairs
	output wire logic [HALL_W-1:0] hall_a_pos,
	output wire logic [HALL_W-1:0] hall_a_neg,
	output wire logic [HALL_W-1:0] hall_b_pos,
	output wire logic [HALL_W-1:0] hall_b_neg,
	output wire logic [HALL_W-1:0] hall_c_pos,
	output wire logic [HALL_W-1:0] hall_c_neg,
	// low-side enables and pin level
	input  wire logic [2:0]        sink_oe_n,
	output wire logic [2:0]        sink_pin
);
	// full swing per sensor, so a pair never ties
	assign hall_a_pos = {HALL_W{hall_code[2]}};
	assign hall_a_neg = {HALL_W{~hall_code[2]}};
	assign hall_b_pos = {HALL_W{hall_code[1]}};
	assign hall_b_neg = {HALL_W{~hall_code[1]}};
	assign hall_c_pos = {HALL_W{hall_code[0]}};
	assign hall_c_neg = {HALL_W{~hall_code[0]}};
	// open collector: pull-up wins when released
	assign sink_pin = sink_oe_n;
endmodule // bcpg_motor
`default_nettype wire

// *** dv/bcpg_core_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker for the gating core
module bcpg_core_asserts #(
	parameter HALL_W = 1
) (
	// clock and reset
	input wire logic              CORE_CLK,
	input wire logic              ARST_N,
	// control pins
	input wire logic              START_STOP_INPUT,
	input wire logic              PULSE_DUTY_INPUT,
	// hall inputs
	input wire logic [HALL_W-1:0] HALL_A_POS,
	input wire logic [HALL_W-1:0] HALL_A_NEG,
	input wire logic [HALL_W-1:0] HALL_B_POS,
	input wire logic [HALL_W-1:0] HALL_B_NEG,
	input wire logic [HALL_W-1:0] HALL_C_POS,
	input wire logic [HALL_W-1:0] HALL_C_NEG,
	// drives
	input wire logic              PHASE_A_HIGH_DRIVE,
	input wire logic              PHASE_B_HIGH_DRIVE,
	input wire logic              PHASE_C_HIGH_DRIVE,
	input wire logic              PHASE_A_LOW_DRIVE_OE_N,
	input wire logic              PHASE_B_LOW_DRIVE_OE_N,
	input wire logic              PHASE_C_LOW_DRIVE_OE_N,
	// status and bus
	input wire logic              ROTATION_STATUS,
	input wire logic              WB_ACK_O
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	// ==========================================
	// derived state, bit0 is phase a in src and sink; code is {a,b,c}, bit2 is a
	wire [2:0] src  = {PHASE_C_HIGH_DRIVE, PHASE_B_HIGH_DRIVE,
		PHASE_A_HIGH_DRIVE};
	wire [2:0] sink = ~{PHASE_C_LOW_DRIVE_OE_N, PHASE_B_LOW_DRIVE_OE_N,
		PHASE_A_LOW_DRIVE_OE_N};
	wire       off  = (src == 3'h0) && (sink == 3'h0);
	wire [2:0] code = {HALL_A_POS > HALL_A_NEG, HALL_B_POS > HALL_B_NEG,
		HALL_C_POS > HALL_C_NEG};
	wire       bad  = (code == 3'h0) || (code == 3'h7);
	reg  [11:0] since_rst;  // edges since release, saturating
	// count from release; saturates so it never wraps into the hold
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			since_rst <= 12'h000;
		end else if (since_rst != 12'hFFF) begin
			since_rst <= since_rst + 12'h001;
		end
	end
	// ==========================================
	// properties
	property p_stop_off; START_STOP_INPUT [*3] |-> off; endproperty
	property p_duty_off; PULSE_DUTY_INPUT [*3] |-> off; endproperty
	property p_no_shoot; (src & sink) == 3'h0; endproperty
	property p_bad_off; bad [*3] |-> off; endproperty
	property p_one_src; $onehot0(src); endproperty
	property p_pair; $onehot0(sink) && (src == 3'h0 || sink != 3'h0);
	endproperty
	property p_lock_off; !ROTATION_STATUS [*2] |-> off; endproperty
	property p_init_hold; since_rst < 12'h7D0 |-> off; endproperty
	a_stop_off: assert property (p_stop_off)
		else $error("drive while stopped");
	a_duty_off: assert property (p_duty_off)
		else $error("drive while duty input high");
	a_no_shoot: assert property (p_no_shoot)
		else $error("both sides of one phase on");
	a_bad_off: assert property (p_bad_off)
		else $error("drive on invalid hall code");
	a_one_src: assert property (p_one_src)
		else $error("more than one source");
	a_pair: assert property (p_pair)
		else $error("source without single sink");
	a_lock_off: assert property (p_lock_off)
		else $error("drive while lock shut down");
	a_init_hold: assert property (p_init_hold)
		else $error("drive during initial hold");
	c_ack: cover property (WB_ACK_O);
	c_drive: cover property (src != 3'h0);
	c_lock: cover property ($fell(ROTATION_STATUS));
endmodule // bcpg_core_asserts
bind bcpg_core bcpg_core_asserts #(.HALL_W(HALL_W)) bcpg_core_asserts_inst (
	.CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
	.START_STOP_INPUT(START_STOP_INPUT), .PULSE_DUTY_INPUT(PULSE_DUTY_INPUT),
	.HALL_A_POS(HALL_A_POS), .HALL_A_NEG(HALL_A_NEG),
	.HALL_B_POS(HALL_B_POS), .HALL_B_NEG(HALL_B_NEG),
	.HALL_C_POS(HALL_C_POS), .HALL_C_NEG(HALL_C_NEG),
	.PHASE_A_HIGH_DRIVE(PHASE_A_HIGH_DRIVE),
	.PHASE_B_HIGH_DRIVE(PHASE_B_HIGH_DRIVE),
	.PHASE_C_HIGH_DRIVE(PHASE_C_HIGH_DRIVE),
	.PHASE_A_LOW_DRIVE_OE_N(PHASE_A_LOW_DRIVE_OE_N),
	.PHASE_B_LOW_DRIVE_OE_N(PHASE_B_LOW_DRIVE_OE_N),
	.PHASE_C_LOW_DRIVE_OE_N(PHASE_C_LOW_DRIVE_OE_N),
	.ROTATION_STATUS(ROTATION_STATUS), .WB_ACK_O(WB_ACK_O));
`default_nettype wire

// *** dv/bldc_commutation_pwm_gating_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bcpg_regs.vh"
// ==========================================
// bench for the commutation and gating core
module bldc_commutation_pwm_gating_bench;
	localparam LOCK_N  = 200;  // shortened lock time
	localparam RECOV_N = 300;  // shortened recovery time
	logic        clk = 1'b0;      // 25 MHz core clock
	logic        arst_n = 1'b0;   // held low at start
	logic        cyc = 1'b0;      // bus cycle
	logic        we = 1'b0;       // bus direction
	logic [7:0]  adr = 8'h00;     // bus address
	logic [31:0] wdat = 32'h0000_0000;
	logic        stop_in = 1'b1;  // pulled up: stopped
	logic        duty_in = 1'b0;  // unused duty input low
	logic        lock_in = 1'b0;  // grounded: no protection
	logic [2:0]  hall = 3'h0;     // wanted hall state
	wire  [31:0] rdat;
	wire         ack, rot, irq;
	wire  [2:0]  src, oe_n, pin;
	wire         ap, an, bp, bn, cp, cn;
	logic [31:0] rd;              // last read word
	integer      miscompares = 0, checks_done = 0, cycles = 0;
	integer      i, d, n, k;
	always #20 clk = ~clk;
	bcpg_core #(.LOCK_CYCLES(LOCK_N), .RECOV_CYCLES(RECOV_N)) bcpg_core_inst (
		.CORE_CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .START_STOP_INPUT(stop_in),
		.PULSE_DUTY_INPUT(duty_in), .LOCK_TIMER_INPUT(lock_in),
		.HALL_A_POS(ap), .HALL_A_NEG(an), .HALL_B_POS(bp), .HALL_B_NEG(bn),
		.HALL_C_POS(cp), .HALL_C_NEG(cn), .PHASE_A_HIGH_DRIVE(src[0]),
		.PHASE_B_HIGH_DRIVE(src[1]), .PHASE_C_HIGH_DRIVE(src[2]),
		.PHASE_A_LOW_DRIVE_I(pin[0]), .PHASE_A_LOW_DRIVE_O(),
		.PHASE_A_LOW_DRIVE_OE_N(oe_n[0]), .PHASE_B_LOW_DRIVE_I(pin[1]),
		.PHASE_B_LOW_DRIVE_O(), .PHASE_B_LOW_DRIVE_OE_N(oe_n[1]),
		.PHASE_C_LOW_DRIVE_I(pin[2]), .PHASE_C_LOW_DRIVE_OE_N(oe_n[2]),
		.PHASE_C_LOW_DRIVE_O(), .ROTATION_STATUS(rot), .IRQ(irq));
	bcpg_motor bcpg_motor_inst (.hall_code(hall), .hall_a_pos(ap),
		.hall_a_neg(an), .hall_b_pos(bp), .hall_b_neg(bn), .hall_c_pos(cp),
		.hall_c_neg(cn), .sink_oe_n(oe_n), .sink_pin(pin));
	// ==========================================
	// shared tasks
	task chk(input [31:0] got, input [31:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one classic cycle; the wait only ends on ack or the bench limit
	task wb(input w, input [7:0] a, input [31:0] dat);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= dat;
		do @(posedge clk); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task rdchk(input [7:0] a, input [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask
	// set pins and hall, let two flop stages settle, compare drives
	task look(input [2:0] c, input s, input p, input [5:0] e);
		hall <= c;
		stop_in <= s;
		duty_in <= p;
		repeat (4) @(posedge clk);
		chk({src, ~oe_n}, e);
	endtask
	// {source a..c high bits, sink bits} per hall code, direction 0
	function [5:0] pick(input [2:0] c);
		case (c)
			3'h5: pick = 6'h11;
			3'h4: pick = 6'h21;
			3'h6: pick = 6'h22;
			3'h2: pick = 6'h0A;
			3'h3: pick = 6'h0C;
			3'h1: pick = 6'h14;
			default: pick = 6'h00;  // invalid codes drive nothing
		endcase
	endfunction
	task complete_run;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// hang guard, well above the ~7600 cycles the tests need
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			complete_run;
		end
	end
	// ==========================================
	// test sequence
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		rdchk(`BCPG_OFS_CTRL, 32'h0000_0000);
		rdchk(`BCPG_OFS_TORQUE, 32'h0000_0000);
		rdchk(`BCPG_OFS_IRQ_EN, 32'h0000_0000);
		wb(1'b1, 8'h40, 32'h0000_00FF);
		rdchk(8'h40, 32'h0000_0000);
		wb(1'b1, `BCPG_OFS_TORQUE, 32'h0000_00FF);  // full duty
		rdchk(`BCPG_OFS_TORQUE, 32'h0000_00FF);
		$display("test registers done");
		look(3'h5, 1'b0, 1'b0, 6'h00);
		repeat (2400) @(posedge clk);
		look(3'h5, 1'b0, 1'b0, pick(3'h5));
		$display("test init done");
		for (d = 0; d < 2; d = d + 1) begin
			wb(1'b1, `BCPG_OFS_CTRL, d);
			for (i = 0; i < 8; i = i + 1)
				look(i[2:0], 1'b0, 1'b0, pick(i[2:0] ^ {3{d[0]}}));
		end
		wb(1'b1, `BCPG_OFS_CTRL, 32'h0000_0000);
		look(3'h5, 1'b0, 1'b0, pick(3'h5));
		$display("test commutation done");
		look(3'h5, 1'b1, 1'b0, 6'h00);
		look(3'h5, 1'b0, 1'b0, pick(3'h5));
		look(3'h5, 1'b0, 1'b1, 6'h00);
		look(3'h5, 1'b0, 1'b0, pick(3'h5));
		rdchk(`BCPG_OFS_STATUS, 32'h0000_0375);
		$display("test gating done");
		rdchk(`BCPG_OFS_IRQ_STAT, 32'h0000_0005);
		wb(1'b1, `BCPG_OFS_IRQ_EN, 32'h0000_0001);
		repeat (3) @(posedge clk);
		chk(irq, 1'b1);
		wb(1'b1, `BCPG_OFS_IRQ_EN, 32'h0000_0000);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		wb(1'b1, `BCPG_OFS_IRQ_EN, 32'h0000_0005);
		wb(1'b1, `BCPG_OFS_IRQ_CLR, 32'h0000_0001);
		rdchk(`BCPG_OFS_IRQ_STAT, 32'h0000_0004);
		chk(irq, 1'b1);
		wb(1'b1, `BCPG_OFS_IRQ_CLR, 32'h0000_0004);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		$display("test interrupts done");
		for (d = 8'h80; d > 8'h20; d = d - 8'h40) begin
			wb(1'b1, `BCPG_OFS_TORQUE, d);
			repeat (`BCPG_PWM_PERIOD) @(posedge clk);
			n = 0;
			repeat (`BCPG_PWM_PERIOD) begin
				@(posedge clk);
				n = n + (src[1] ? 1 : 0);
			end
			chk(n, (d * `BCPG_PWM_PERIOD) >> 8);
			chk({~oe_n}, 3'h1);
		end
		$display("test duty done");
		wb(1'b1, `BCPG_OFS_TORQUE, 32'h0000_00FF);
		lock_in <= 1'b1;  // protection fitted
		repeat (LOCK_N + 20) @(posedge clk);
		chk(rot, 1'b0);
		chk({src, ~oe_n}, 6'h00);
		wb(1'b0, `BCPG_OFS_IRQ_STAT, 32'h0000_0000);
		chk(rd[1], 1'b1);
		k = 0;
		while (rot !== 1'b1 && k < RECOV_N + 100) begin
			@(posedge clk);
			k = k + 1;
		end
		chk(rot, 1'b1);
		lock_in <= 1'b0;
		$display("test lock done");
		complete_run;
	end
endmodule // bldc_commutation_pwm_gating_bench
`default_nettype wire
